// [ufcs_top.sv]
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "ufcs_consts.svh"
module ufcs_top #(
	parameter int DEPTH      = 8,
	parameter int RESUME_CYC = `UFCS_RESUME_CYC
) (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                srst,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata_r,
	// USB engine side
	input  wire logic                usb_bus_reset,
	input  wire logic                usb_suspend,
	output logic                     usb_enum_en_r,
	output logic                     remote_wake_r,
	output logic                     resume_drive_r,
	output ufcs_pkg::ufcs_desc_t     desc_r,
	// FIFO side
	input  wire logic                rx_fifo_ready,
	output logic                     fifo_en_r,
	output logic                     fifo_pull_down_r,
	output logic                     hi_drive_r,
	output logic                     power_enable_n_r,
	// Receive flag pin
	input  wire logic                rx_data_avail_n_in,
	output logic                     rx_data_avail_n_out_r,
	output logic                     rx_data_avail_n_oe_r,
	// Clock source
	input  wire logic                ext_osc_present,
	output logic                     osc_ext_sel_r,
	output logic                     clock_fail_r
);
	import ufcs_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	// ****************************************************************
	// Load sequencer state
	// ****************************************************************
	ufcs_ld_state_t  st_r;
	ufcs_ld_state_t  st_nxt;
	logic [AW-1:0]   ld_addr_r;
	logic [AW-1:0]   rd_idx_r;
	logic            rd_vld_r;
	logic [15:0]     stage_r [DEPTH];
	logic [AW-1:0]   nvm_addr_r;
	logic            cfg_valid_r;
	logic            wake_pulse;
	logic            resume_act;
	logic [15:0]     nvm_rdata;
	ufcs_desc_t      staged;

	// ****************************************************************
	// Register decode
	// ****************************************************************
	wire hit_ctrl   = reg_addr == `UFCS_REG_CTRL;
	wire hit_naddr  = reg_addr == `UFCS_REG_NVM_ADDR;
	wire hit_ndata  = reg_addr == `UFCS_REG_NVM_DATA;
	wire loading    = st_r != LD_IDLE;
	wire reload_req = reg_wr && hit_ctrl && reg_wdata[0];
	wire restart    = usb_bus_reset || reload_req;
	// rewrites land in the store, used only at next load
	wire nvm_we     = reg_wr && hit_ndata && !loading && !restart;
	wire [AW-1:0] mem_addr = loading ? ld_addr_r : nvm_addr_r;

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (reg_addr == `UFCS_REG_STATUS) begin
			rd_mux = {26'h0, resume_act, clock_fail_r, osc_ext_sel_r,
				usb_suspend && cfg_valid_r, loading, cfg_valid_r};
		end else if (hit_naddr) begin
			rd_mux = 32'(nvm_addr_r);
		end else if (hit_ndata) begin
			rd_mux = {25'h0, desc_r.self_pwr, desc_r.ext_osc, desc_r.ser_drv,
				desc_r.hi_drive, desc_r.remote_wake, desc_r.susp_pd,
				desc_r.serial_en};
		end else if (reg_addr == `UFCS_REG_BCD_USB) begin
			rd_mux = {16'h0, desc_r.bcd_usb};
		end else if (reg_addr == `UFCS_REG_POWER) begin
			rd_mux = {15'h0, desc_r.self_pwr, desc_r.max_ma};
		end else if (reg_addr == `UFCS_REG_SERIAL) begin
			rd_mux = desc_r.serial;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata_r <= 32'h0;
			nvm_addr_r  <= '0;
		end else begin
			reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
			if (reg_wr && hit_naddr) begin
				nvm_addr_r <= reg_wdata[AW-1:0];
			end
		end
	end

	// ****************************************************************
	// Nonvolatile store
	// ****************************************************************
	ufcs_nvm #(
		.W     (16),
		.DEPTH (DEPTH),
		.INIT  ({{(DEPTH - 7){`UFCS_DEF_SPARE}}, `UFCS_DEF_PID, `UFCS_DEF_VID,
			`UFCS_DEF_SER_HI, `UFCS_DEF_SER_LO, `UFCS_DEF_PWR_MA,
			`UFCS_DEF_BCD, `UFCS_DEF_OPT})
	) u_nvm (
		.core_clk (core_clk),
		.we       (nvm_we),
		.addr     (mem_addr),
		.wdata    (reg_wdata[15:0]),
		.rdata_r  (nvm_rdata)
	);

	// ****************************************************************
	// Load sequencer
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			LD_IDLE:  st_nxt = LD_IDLE;
			LD_SCAN:  st_nxt = (ld_addr_r == LAST) ? LD_DRAIN : LD_SCAN;
			LD_DRAIN: st_nxt = LD_APPLY;
			LD_APPLY: st_nxt = LD_IDLE;
			default:  st_nxt = LD_IDLE;
		endcase
		if (restart) begin
			st_nxt = LD_SCAN;
		end
	end

	// read every word of the store
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r      <= LD_SCAN;
			ld_addr_r <= '0;
			rd_vld_r  <= 1'b0;
			rd_idx_r  <= '0;
		end else begin
			st_r     <= st_nxt;
			rd_vld_r <= (st_r == LD_SCAN) && !restart;
			rd_idx_r <= ld_addr_r;
			if (restart || st_r != LD_SCAN) begin
				ld_addr_r <= '0;
			end else begin
				ld_addr_r <= ld_addr_r + AW'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rd_vld_r) begin
			stage_r[rd_idx_r] <= nvm_rdata;
		end
	end

	always_comb begin
		staged             = '0;
		staged.serial_en   = stage_r[`UFCS_W_OPT][`UFCS_B_SERIAL];
		staged.susp_pd     = stage_r[`UFCS_W_OPT][`UFCS_B_SUSP_PD];
		staged.remote_wake = stage_r[`UFCS_W_OPT][`UFCS_B_WAKE];
		staged.hi_drive    = stage_r[`UFCS_W_OPT][`UFCS_B_HI_DRIVE];
		staged.ser_drv     = stage_r[`UFCS_W_OPT][`UFCS_B_SER_DRV];
		staged.ext_osc     = stage_r[`UFCS_W_OPT][`UFCS_B_EXT_OSC];
		staged.self_pwr    = stage_r[`UFCS_W_OPT][`UFCS_B_SELF_PWR];
		staged.bcd_usb     = stage_r[`UFCS_W_BCD];
		staged.max_ma      = stage_r[`UFCS_W_PWR];
		if (staged.serial_en) begin
			staged.serial = {stage_r[`UFCS_W_SER_HI], stage_r[`UFCS_W_SER_LO]};
		end
		staged.vid         = stage_r[`UFCS_W_VID];
		staged.pid         = stage_r[`UFCS_W_PID];
	end

	// apply all options in one edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			desc_r        <= '0;
			cfg_valid_r   <= 1'b0;
			osc_ext_sel_r <= 1'b0;
		end else if (restart) begin
			cfg_valid_r   <= 1'b0;
		end else if (st_r == LD_APPLY) begin
			desc_r        <= staged;
			cfg_valid_r   <= 1'b1;
			// external source only from stored option
			osc_ext_sel_r <= staged.ext_osc;
		end
	end

	// ****************************************************************
	// Pin and enable control
	// ****************************************************************
	// no clock when external chosen and absent
	wire clk_bad   = osc_ext_sel_r && !ext_osc_present;
	wire active    = cfg_valid_r && !clk_bad;
	wire suspended = active && usb_suspend;
	// flag pin becomes input in suspend when the remote wakeup option is set
	wire pin_input = suspended && desc_r.remote_wake;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			clock_fail_r          <= 1'b0;
			usb_enum_en_r         <= 1'b0;
			fifo_en_r             <= 1'b0;
			fifo_pull_down_r      <= 1'b0;
			hi_drive_r            <= 1'b0;
			power_enable_n_r      <= 1'b1;
			rx_data_avail_n_out_r <= 1'b1;
			rx_data_avail_n_oe_r  <= 1'b1;
			remote_wake_r         <= 1'b0;
			resume_drive_r        <= 1'b0;
		end else begin
			clock_fail_r          <= clk_bad;
			// enumeration and FIFO wait for load
			usb_enum_en_r         <= active;
			fifo_en_r             <= active && !usb_suspend;
			fifo_pull_down_r      <= suspended && desc_r.susp_pd;
			hi_drive_r            <= active && desc_r.hi_drive;
			power_enable_n_r      <= !(active && !usb_suspend);
			rx_data_avail_n_out_r <= !(active && !usb_suspend && rx_fifo_ready);
			rx_data_avail_n_oe_r  <= !pin_input;
			remote_wake_r         <= wake_pulse;
			resume_drive_r        <= resume_act;
		end
	end

	ufcs_wake #(
		.RESUME_CYC (RESUME_CYC)
	) u_wake (
		.core_clk     (core_clk),
		.srst         (srst),
		.armed        (pin_input && !rx_data_avail_n_oe_r),
		.pin_in       (rx_data_avail_n_in),
		.wake_pulse_r (wake_pulse),
		.resume_r     (resume_act)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	// bus reset restarts
	a_load_restart : assert property (@(posedge core_clk) disable iff (srst)
		usb_bus_reset |=> !cfg_valid_r && st_r == LD_SCAN)
		else $error("bus reset did not restart load");

	a_load_length : assert property (@(posedge core_clk) disable iff (srst)
		$rose(cfg_valid_r) |-> $past(st_r) == LD_APPLY)
		else $error("config valid without apply");

	a_gate_fifo : assert property (@(posedge core_clk) disable iff (srst)
		!cfg_valid_r |=> !fifo_en_r && !usb_enum_en_r)
		else $error("fifo active before load");

	a_pull_down : assert property (@(posedge core_clk) disable iff (srst)
		fifo_pull_down_r |-> $past(desc_r.susp_pd) && $past(usb_suspend))
		else $error("pull down outside suspend option");

	a_flag_input : assert property (@(posedge core_clk) disable iff (srst)
		(suspended && desc_r.remote_wake) |=> !rx_data_avail_n_oe_r)
		else $error("flag pin still driven in suspend");

	a_wake_strobe : assert property (@(posedge core_clk) disable iff (srst)
		(wake_pulse) |=> remote_wake_r && resume_drive_r)
		else $error("wakeup not signalled");

	a_version_out : assert property (@(posedge core_clk) disable iff (srst)
		$rose(cfg_valid_r) |-> desc_r.bcd_usb == $past(stage_r[`UFCS_W_BCD]))
		else $error("version not as stored");

	a_power_rep : assert property (@(posedge core_clk) disable iff (srst)
		$rose(cfg_valid_r) |-> desc_r.max_ma == $past(stage_r[`UFCS_W_PWR]))
		else $error("power not as stored");

	a_osc_fail : assert property (@(posedge core_clk) disable iff (srst)
		(osc_ext_sel_r && !ext_osc_present) |=> clock_fail_r && !fifo_en_r)
		else $error("runs without clock");

	a_hi_drive : assert property (@(posedge core_clk) disable iff (srst)
		hi_drive_r |-> $past(desc_r.hi_drive))
		else $error("high drive without option");

	a_serial_gate : assert property (@(posedge core_clk) disable iff (srst)
		!desc_r.serial_en |-> desc_r.serial == 32'h0)
		else $error("serial shown while disabled");

	// source changes at apply; reset returns to internal
	a_osc_default : assert property (@(posedge core_clk) disable iff (srst)
		$changed(osc_ext_sel_r) |-> $past(st_r) == LD_APPLY || $past(srst))
		else $error("clock source changed outside load");

	a_drv_apply : assert property (@(posedge core_clk) disable iff (srst)
		$changed(desc_r.ser_drv) |-> $past(st_r) == LD_APPLY || $past(srst))
		else $error("driver option changed outside load");

endmodule : ufcs_top

// [ufcs_consts.svh]
// Functional notes
// - Every power-on and USB bus reset rescans the store and loads the configuration.
// - Suspend pull-down option pulls FIFO lines low while suspended; default off.
// - Remote wakeup option turns the receive flag pin into an input in suspend.
// - A low strobe on that pin in suspend raises remote wakeup; default enabled.
// - Report stored USB version, default 0200; speed stays full speed 12Mb/s.
// - Report stored maximum current and power source; defaults 90mA, bus powered.
// - Internal oscillator by default; external only after the store is rewritten.
// - External source selected but absent means no clock; device stays inactive.
// - High-current option selects high drive on FIFO pins; default off.
// - Serial-number option reports the stored unique serial; default on.
// - Driver-selection option presents the serial port driver configuration; default on.
`ifndef UFCS_CONSTS_SVH
`define UFCS_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define UFCS_REG_STATUS   8'h00
`define UFCS_REG_CTRL     8'h04
`define UFCS_REG_NVM_ADDR 8'h08
`define UFCS_REG_NVM_DATA 8'h0c
`define UFCS_REG_BCD_USB  8'h10
`define UFCS_REG_POWER    8'h14
`define UFCS_REG_SERIAL   8'h18

// ****************************************************************
// Store layout: word index and option bit positions
// ****************************************************************
`define UFCS_W_OPT       3'h0
`define UFCS_W_BCD       3'h1
`define UFCS_W_PWR       3'h2
`define UFCS_W_SER_LO    3'h3
`define UFCS_W_SER_HI    3'h4
`define UFCS_W_VID       3'h5
`define UFCS_W_PID       3'h6
`define UFCS_B_SERIAL    0
`define UFCS_B_SUSP_PD   1
`define UFCS_B_WAKE      2
`define UFCS_B_HI_DRIVE  3
`define UFCS_B_SER_DRV   4
`define UFCS_B_EXT_OSC   5
`define UFCS_B_SELF_PWR  6

// ****************************************************************
// Factory values (vendor and product codes are arbitrary)
// ****************************************************************
`define UFCS_DEF_OPT     16'h0015
`define UFCS_DEF_BCD     16'h0200
`define UFCS_DEF_PWR_MA  16'h005a
`define UFCS_DEF_SER_LO  16'h0001
`define UFCS_DEF_SER_HI  16'h0000
`define UFCS_DEF_VID     16'h1234
`define UFCS_DEF_PID     16'h5678
`define UFCS_DEF_SPARE   16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define UFCS_CLK_MHZ        125
`define UFCS_RESUME_TIME_MS 20
`define UFCS_RESUME_CYC     (`UFCS_RESUME_TIME_MS * 1000 * `UFCS_CLK_MHZ)

`endif

// [ufcs_pkg.sv]
package ufcs_pkg;

	typedef struct packed {
		logic        serial_en;
		logic        susp_pd;
		logic        remote_wake;
		logic        hi_drive;
		logic        ser_drv;
		logic        ext_osc;
		logic        self_pwr;
		logic [15:0] bcd_usb;
		logic [15:0] max_ma;
		logic [31:0] serial;
		logic [15:0] vid;
		logic [15:0] pid;
	} ufcs_desc_t;

	typedef enum logic [1:0] {
		LD_IDLE,
		LD_SCAN,
		LD_DRAIN,
		LD_APPLY
	} ufcs_ld_state_t;

endpackage : ufcs_pkg

// [ufcs_nvm.sv]
`timescale 1ns/1ps
module ufcs_nvm #(
	parameter int              W     = 16,
	parameter int              DEPTH = 8,
	parameter logic [W*DEPTH-1:0] INIT = '0
) (
	// Clock
	input  wire logic                     core_clk,
	// Access port
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] addr,
	input  wire logic [W-1:0]             wdata,
	output logic      [W-1:0]             rdata_r
);

	logic [W-1:0] mem [DEPTH];

	// Contents survive srst: this models the nonvolatile store
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = INIT[i*W +: W];
		end
	end

	// Plain always: the initial block above also writes the array
	always @(posedge core_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		rdata_r <= mem[addr];
	end

endmodule : ufcs_nvm

// [ufcs_wake.sv]
`timescale 1ns/1ps
module ufcs_wake #(
	parameter int RESUME_CYC = 2500000
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Conditions
	input  wire logic armed,
	input  wire logic pin_in,
	// Wakeup outputs
	output logic      wake_pulse_r,
	output logic      resume_r
);

	logic        pin_d_r;
	logic [31:0] cnt_r;
	wire         strobe = armed && pin_d_r && !pin_in;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_d_r      <= 1'b1;
			cnt_r        <= '0;
			wake_pulse_r <= 1'b0;
			resume_r     <= 1'b0;
		end else begin
			pin_d_r      <= pin_in;
			wake_pulse_r <= strobe && !resume_r;
			if (strobe && !resume_r) begin
				resume_r <= 1'b1;
				cnt_r    <= 32'(RESUME_CYC - 1);
			end else if (resume_r) begin
				if (cnt_r == '0) begin
					resume_r <= 1'b0;
				end else begin
					cnt_r <= cnt_r - 32'h1;
				end
			end
		end
	end

	a_resume_hold : assert property (@(posedge core_clk) disable iff (srst)
		$rose(resume_r) |-> resume_r [*8])
		else $error("resume dropped early");

endmodule : ufcs_wake

// [ufcs_ext_logic.sv]
`timescale 1ns/1ps
module ufcs_ext_logic #(
	parameter int STROBE_CYC = 3
) (
	// Clock
	input  wire logic core_clk,
	// Device side
	input  wire logic power_enable_n,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	// Bench command
	input  wire logic wake_req,
	// Resolved flag pin
	output logic      pin_level
);
	int   low_cnt = 0;
	logic powered;

	// ********
	// Outside logic
	// ********
	// sleeps in suspend
	assign powered = !power_enable_n;

	always @(posedge core_clk) begin
		if (wake_req && !powered)
			low_cnt <= STROBE_CYC;
		else if (low_cnt > 0)
			low_cnt <= low_cnt - 1;
	end

	// pull-up holds the pin high when nobody drives it
	assign pin_level = pin_oe ? pin_out : (low_cnt > 0 ? 1'b0 : 1'b1);
endmodule : ufcs_ext_logic

// [usb_fifo_config_suspend_control_bench.sv]
`timescale 1ns/1ps
`include "ufcs_consts.svh"
module usb_fifo_config_suspend_control_bench;
	import ufcs_pkg::*;
	localparam int RCYC = 16;
	logic        core_clk, srst, reg_wr, reg_rd, usb_bus_reset, usb_suspend;
	logic        rx_fifo_ready, ext_osc_present, wake_req, pin_level, ok, osc_in;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata_r;
	logic        usb_enum_en_r, remote_wake_r, resume_drive_r, fifo_en_r, fifo_pull_down_r;
	logic        hi_drive_r, power_enable_n_r, rx_data_avail_n_out_r, rx_data_avail_n_oe_r;
	logic        osc_ext_sel_r, clock_fail_r;
	logic [15:0] opt;
	ufcs_desc_t  desc_r, e;
	int          fails, samples_checked, seed, i, k, n_wake, n_res;
	int          st [8];

	ufcs_top #(.RESUME_CYC(RCYC)) ufcs_top_i (
		.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
		.usb_bus_reset, .usb_suspend, .usb_enum_en_r, .remote_wake_r, .resume_drive_r,
		.desc_r, .rx_fifo_ready, .fifo_en_r, .fifo_pull_down_r, .hi_drive_r,
		.power_enable_n_r, .rx_data_avail_n_in(pin_level), .rx_data_avail_n_out_r,
		.rx_data_avail_n_oe_r, .ext_osc_present, .osc_ext_sel_r, .clock_fail_r
	);

	ufcs_ext_logic ufcs_ext_logic_i (
		.core_clk, .power_enable_n(power_enable_n_r), .pin_out(rx_data_avail_n_out_r),
		.pin_oe(rx_data_avail_n_oe_r), .wake_req, .pin_level
	);

	// ********
	// Helpers
	// ********
	task automatic report_and_stop();
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		@(negedge core_clk);
		chk(what, reg_rdata_r, exp);
	endtask : rd

	// Clock-fail loads never enable, so that case watches the whole window
	task automatic wait_load(input logic good);
		int c;
		c = 0;
		while (good && usb_enum_en_r !== 1'b1 && c < 40) begin
			@(negedge core_clk);
			c++;
		end
		if (c == 40) begin
			fails++;
			report_and_stop();
		end
		if (!good) begin
			repeat (40) begin
				@(negedge core_clk);
				chk("enum_dead", usb_enum_en_r, 1'b0);
			end
		end
	endtask : wait_load

	task automatic check_cfg();
		e = '0;
		e.serial_en   = opt[`UFCS_B_SERIAL];
		e.susp_pd     = opt[`UFCS_B_SUSP_PD];
		e.remote_wake = opt[`UFCS_B_WAKE];
		e.hi_drive    = opt[`UFCS_B_HI_DRIVE];
		e.ser_drv     = opt[`UFCS_B_SER_DRV];
		e.ext_osc     = opt[`UFCS_B_EXT_OSC];
		e.self_pwr    = opt[`UFCS_B_SELF_PWR];
		e.bcd_usb     = st[1][15:0];
		e.max_ma      = st[2][15:0];
		e.serial      = e.serial_en ? {st[4][15:0], st[3][15:0]} : 32'h0;
		e.vid         = st[5][15:0];
		e.pid         = st[6][15:0];
		@(negedge core_clk);
		chk("desc", desc_r, e);
		chk("hi_drive", hi_drive_r, opt[3] & !(opt[5] & !ext_osc_present));
		chk("osc_sel", osc_ext_sel_r, opt[5]);
		chk("clk_fail", clock_fail_r, opt[5] & !ext_osc_present);
		rd("bcd", `UFCS_REG_BCD_USB, st[1]);
		rd("power", `UFCS_REG_POWER, {15'h0, opt[6], st[2][15:0]});
		rd("serial", `UFCS_REG_SERIAL, e.serial);
		rd("options", `UFCS_REG_NVM_DATA, {25'h0, opt[6:0]});
		rd("unmapped", 8'hfc, 32'h0);
	endtask : check_cfg

	task automatic suspend_check();
		@(posedge core_clk);
		usb_suspend <= 1'b1;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk("pwr_en_susp", power_enable_n_r, 1'b1);
		chk("pull_down", fifo_pull_down_r, opt[1]);
		chk("pin_oe_susp", rx_data_avail_n_oe_r, !opt[2]);
		chk("fifo_en_susp", fifo_en_r, 1'b0);
		chk("rx_flag_susp", rx_data_avail_n_out_r, 1'b1);
		@(posedge core_clk);
		wake_req <= 1'b1;
		@(posedge core_clk);
		wake_req <= 1'b0;
		n_wake = 0;
		n_res = 0;
		repeat (40) begin
			@(negedge core_clk);
			if (remote_wake_r === 1'b1)
				n_wake++;
			if (resume_drive_r === 1'b1)
				n_res++;
		end
		chk("wake_pulses", n_wake, opt[2]);
		chk("resume_len", n_res, opt[2] ? RCYC : 0);
		@(posedge core_clk);
		usb_suspend <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("pwr_en_run", power_enable_n_r, 1'b0);
		chk("fifo_en_run", fifo_en_r, 1'b1);
		chk("pin_oe_run", rx_data_avail_n_oe_r, 1'b1);
		chk("rx_flag_run", rx_data_avail_n_out_r, !rx_fifo_ready);
	endtask : suspend_check

	// ********
	// Stimulus
	// ********
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		seed = 32'h9dc99ba5;
		{srst, reg_wr, reg_rd, usb_bus_reset, usb_suspend, wake_req} = 6'h20;
		{reg_addr, reg_wdata, rx_fifo_ready, ext_osc_present} = '0;
		fails = 0;
		samples_checked = 0;
		st = '{`UFCS_DEF_OPT, `UFCS_DEF_BCD, `UFCS_DEF_PWR_MA, `UFCS_DEF_SER_LO,
			`UFCS_DEF_SER_HI, `UFCS_DEF_VID, `UFCS_DEF_PID, `UFCS_DEF_SPARE};
		opt = st[0][15:0];
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		repeat (3) @(posedge core_clk);
		wait_load(1'b1);
		check_cfg();
		suspend_check();
		for (k = 0; k < 6; k++) begin
			opt = 16'($random(seed)) & 16'h007f;
			osc_in = 1'($random(seed));
			rx_fifo_ready <= 1'($random(seed));
			if (k == 0)
				opt = opt | 16'h0002;
			if (k == 1) begin
				opt = opt | 16'h0020;
				osc_in = 1'b0;
			end
			if (k == 2) begin
				opt = opt | 16'h0020;
				osc_in = 1'b1;
			end
			if (k == 3)
				opt = opt & 16'h007b;
			ext_osc_present <= osc_in;
			st[0] = opt;
			st[1] = $random(seed) & 16'hffff;
			st[3] = $random(seed) & 16'hffff;
			for (i = 0; i < 4; i++) begin
				wr(`UFCS_REG_NVM_ADDR, i);
				wr(`UFCS_REG_NVM_DATA, st[i]);
			end
			@(posedge core_clk);
			if (k == 5)
				srst <= 1'b1;
			else if (k[0])
				reg_wr <= 1'b0;
			else
				usb_bus_reset <= 1'b1;
			if (k[0] && k != 5)
				wr(`UFCS_REG_CTRL, 32'h1);
			@(posedge core_clk);
			srst <= 1'b0;
			usb_bus_reset <= 1'b0;
			repeat (2) @(posedge core_clk);
			@(negedge core_clk);
			chk("enum_drop", usb_enum_en_r, 1'b0);
			ok = !(opt[5] && !ext_osc_present);
			wait_load(ok);
			check_cfg();
			if (ok)
				suspend_check();
		end
		report_and_stop();
	end
endmodule : usb_fifo_config_suspend_control_bench
